// >>> hw/pmlr_top.sv
// pmlr_top: panel modes, loop unit re-initialization, polling, apb regs
// assumes loop events and apb synchronous to REF_CLK, zero-wait slave
//
// The address map and the APB interface to the registers are this design's own decisions.
`timescale 1ns/1ps
// Behaviour
// - reappearing auto-mode unit is checked against record, message shown
// - unambiguous match: restart at former address, clear removed fault
// - unambiguous mismatch: address equals position, mismatch fault, service
// - ambiguous: first free address, uninitialized fault, service zone
// - last unit of area resolves positions, handled as match or mismatch
// - earlier matching units restored, faults cleared, leave service zone
// - earlier mismatching units get position address, fault, stay service
// - manual loop: check identity only, restart at former address
// - power-up verifies every unit against records with message shown
// - poll units in turn while supervising loops and supply
// - duty when no other mode; detector in a zone enters fire
// - fire, fault, disabled, test, info combine freely
// - duty and setup never coexist with others; setup clears all
// - menu enters info unless fatal fault; setup only from info
// - 64 user zones, service zone 0, non-fire zone 255
// - fire drives relay and linked outputs; level 2 may silence
// - input-driven outputs only in fire, never silenced
// - keep a count of active loop inputs
// - extra auto-loop unit gets temporary address and is ignored
// - new manual-loop unit is ignored
// - backlight held in fire, or in fault without mains fault, until stop, off on low battery
module pmlr_top import pmlr_pkg::*; #(
  parameter longint unsigned BL_CYC = BL_TIMEOUT_CYC
) (
  // clock and reset
  input  wire logic                REF_CLK,
  input  wire logic                RST,
  // apb slave
  input  wire logic                PSEL,
  input  wire logic                PENABLE,
  input  wire logic                PWRITE,
  input  wire logic [7:0]          PADDR,
  input  wire logic [31:0]         PWDATA,
  output logic      [31:0]         PRDATA,
  output logic                     PREADY,
  output logic                     PSLVERR,
  // loop unit events
  input  wire logic                UNIT_EVT,
  input  wire logic                UNIT_GONE,
  input  wire logic                UNIT_NEW,
  input  wire logic                UNIT_AMBIG,
  input  wire logic [POS_W-1:0]    UNIT_POS,
  input  wire logic [DATA_W-1:0]   UNIT_DATA,
  output logic                     UNIT_RDY,
  // polling
  output logic                     POLL_REQ,
  output logic      [POS_W-1:0]    POLL_ADDR,
  input  wire logic                POLL_ACK,
  input  wire logic [DATA_W-1:0]   POLL_DATA,
  // supervision and panel inputs
  input  wire logic                FIRE_DET,
  input  wire logic [7:0]          FIRE_ZONE,
  input  wire logic                LOOP_FAULT,
  input  wire logic                VOLT_FAULT,
  input  wire logic                FATAL_FAULT,
  input  wire logic                BATT_LOW,
  input  wire logic                MAINS_FAULT,
  input  wire logic                ACCESS_L2,
  input  wire logic                ACT_IN_SET,
  input  wire logic                ACT_IN_CLR,
  input  wire logic                IN_OUT_REQ,
  // re-initialization results
  output logic                     RES_VALID,
  output logic      [POS_W-1:0]    RES_POS,
  output logic      [ADDR_W-1:0]   RES_ADDR,
  output logic                     RES_MISMATCH,
  output logic                     RES_UNINIT,
  output logic                     RES_IGNORED,
  output logic                     RES_SVC,
  // panel outputs
  output logic                     FIRE_RELAY,
  output logic                     LINKED_OUT,
  output logic                     INPUT_OUT,
  output logic                     BACKLIGHT,
  output logic                     SYSOPS_MSG,
  output logic                     REINIT_MSG,
  output logic                     DUTY,
  output logic                     SETUP
);
  pmlr_state_e          state_reg, state_next;
  logic [N_COND-1:0]    cond_reg;
  logic                 setup_reg, auto_reg, sil_reg, stop_reg;
  logic [POS_W-1:0]     poll_idx_reg, scan_reg, ridx, free_idx;
  logic [POS_W-1:0]     rec_idx_reg;
  logic [N_UNITS-1:0]   removed_reg, pend_reg, match_reg;
  logic [7:0]           act_reg;
  logic [31:0]          rec_q, rd_mux, result_reg;
  logic [ADDR_W-1:0]    rec_addr;
  logic                 wr, rd, full_eq, id_eq, poll_eq, res_flt;
  logic                 evt, last_scan, key_press, bl_on;
  logic [31:0]          prdata_reg;
  logic                 pready_reg, pslverr_reg, hit;
  logic                 relay_reg, linked_reg, inout_reg, sys_reg;
  logic                 rein_reg, rdy_reg, preq_reg;
  logic                 rv_reg, rm_reg, ru_reg, ri_reg, rs_reg;
  logic [POS_W-1:0]     rp_reg;
  logic [ADDR_W-1:0]    ra_reg;

  // apb decode: writes land in the access phase
  assign wr  = PSEL && PENABLE && PWRITE;
  assign rd  = PSEL && !PENABLE;
  assign hit = PADDR inside {A_CTRL, A_COND_SET, A_COND_CLR, A_STATUS,
                             A_ACTIN, A_REC_IDX, A_REC_DATA, A_RESULT, A_KEY};
  assign key_press = wr && PADDR == A_KEY && PWDATA[K_PRESS];
  assign evt = state_reg == PMLR_RUN && UNIT_EVT;
  assign last_scan = scan_reg == POS_W'(N_UNITS - 1);

  pmlr_rec u_rec (
    .clk   (REF_CLK),
    .we    (wr && PADDR == A_REC_DATA),
    .widx  (rec_idx_reg),
    .wdata (PWDATA),
    .ridx  (ridx),
    .rdata (rec_q)
  );

  // record port follows whoever is comparing this cycle
  always_comb begin
    case (state_reg)
      PMLR_RUN:  ridx = UNIT_POS;
      PMLR_WALK: ridx = scan_reg;
      default:   ridx = poll_idx_reg;
    endcase
  end

  assign rec_addr = rec_q[REC_ADDR_LSB +: ADDR_W];
  assign full_eq  = UNIT_DATA == rec_q[DATA_W-1:0];
  assign id_eq    = UNIT_DATA[DATA_W-1:ID_LSB] == rec_q[DATA_W-1:ID_LSB];
  assign poll_eq  = POLL_DATA == rec_q[DATA_W-1:0];

  // lowest removed position is the first free address of the gap
  always_comb begin
    free_idx = '0;
    for (int i = N_UNITS - 1; i >= 0; i--) begin
      if (removed_reg[i]) begin
        free_idx = POS_W'(i);
      end
    end
  end

  always_comb begin
    state_next = state_reg;
    case (state_reg)
      PMLR_SYS:  state_next = PMLR_SYSW;
      PMLR_SYSW: begin
        if (POLL_ACK) begin
          state_next = (poll_idx_reg == POS_W'(N_UNITS - 1)) ?
                       PMLR_RUN : PMLR_SYS;
        end
      end
      PMLR_RUN: begin
        if (evt) begin
          if (auto_reg && !UNIT_GONE && !UNIT_NEW && !UNIT_AMBIG &&
              pend_reg != '0) begin
            state_next = PMLR_WALK;
          end
        end else begin
          state_next = PMLR_POLLW;
        end
      end
      PMLR_POLLW: if (POLL_ACK) state_next = PMLR_RUN;
      PMLR_WALK:  if (last_scan) state_next = PMLR_RUN;
      default:    state_next = PMLR_SYS;
    endcase
  end

  always_ff @(posedge REF_CLK) begin
    if (RST) begin
      state_reg <= PMLR_SYS;
    end else begin
      state_reg <= state_next;
    end
  end

  // polling walk: full pass at power-up, then round robin
  always_ff @(posedge REF_CLK) begin
    if (RST) begin
      poll_idx_reg <= '0;
      preq_reg     <= 1'b0;
    end else begin
      preq_reg <= state_next inside {PMLR_SYSW, PMLR_POLLW} &&
                  !(state_reg inside {PMLR_SYSW, PMLR_POLLW});
      if (state_reg inside {PMLR_SYSW, PMLR_POLLW} && POLL_ACK) begin
        poll_idx_reg <= poll_idx_reg + 1'b1;
      end
    end
  end

  always_ff @(posedge REF_CLK) begin
    if (RST) begin
      scan_reg <= '0;
    end else if (state_reg == PMLR_WALK) begin
      scan_reg <= scan_reg + 1'b1;
    end else begin
      scan_reg <= '0;
    end
  end

  // per-unit removed, pending and match bookkeeping
  always_ff @(posedge REF_CLK) begin
    if (RST) begin
      removed_reg <= '0;
      pend_reg    <= '0;
      match_reg   <= '0;
    end else if (evt && UNIT_GONE) begin
      removed_reg[UNIT_POS] <= 1'b1;
    end else if (evt && !UNIT_NEW) begin
      // pending kept at true position so the walk restores the right unit
      if (auto_reg && UNIT_AMBIG) begin
        removed_reg[free_idx] <= 1'b0;
        pend_reg[UNIT_POS]    <= 1'b1;
        match_reg[UNIT_POS]   <= full_eq;
      end else begin
        removed_reg[UNIT_POS] <= 1'b0;
      end
    end else if (state_reg == PMLR_WALK) begin
      pend_reg[scan_reg] <= 1'b0;
      if (pend_reg[scan_reg]) removed_reg[scan_reg] <= 1'b0;
    end
  end

  // result of each re-initialized unit
  always_ff @(posedge REF_CLK) begin
    if (RST) begin
      rv_reg <= 1'b0;
      rp_reg <= '0;
      ra_reg <= '0;
      rm_reg <= 1'b0;
      ru_reg <= 1'b0;
      ri_reg <= 1'b0;
      rs_reg <= 1'b0;
    end else begin
      rv_reg <= 1'b0;
      if (evt && !UNIT_GONE) begin
        rv_reg <= 1'b1;
        rp_reg <= UNIT_POS;
        rm_reg <= 1'b0;
        ru_reg <= 1'b0;
        ri_reg <= 1'b0;
        rs_reg <= 1'b0;
        if (UNIT_NEW) begin
          ri_reg <= 1'b1;
          ra_reg <= auto_reg ? TEMP_ADDR : '0;
        end else if (!auto_reg) begin
          ra_reg <= rec_addr;
          rm_reg <= !id_eq;
        end else if (UNIT_AMBIG) begin
          ra_reg <= ADDR_W'(free_idx);
          ru_reg <= 1'b1;
          rs_reg <= 1'b1;
        end else if (full_eq) begin
          ra_reg <= rec_addr;
        end else begin
          ra_reg <= ADDR_W'(UNIT_POS);
          rm_reg <= 1'b1;
          rs_reg <= 1'b1;
        end
      end else if (state_reg == PMLR_WALK && pend_reg[scan_reg]) begin
        rv_reg <= 1'b1;
        rp_reg <= scan_reg;
        ru_reg <= 1'b0;
        ri_reg <= 1'b0;
        rm_reg <= !match_reg[scan_reg];
        rs_reg <= !match_reg[scan_reg];
        ra_reg <= match_reg[scan_reg] ? rec_addr
                                      : ADDR_W'(scan_reg);
      end
    end
  end

  assign res_flt = rv_reg && (rm_reg || ru_reg) && !ri_reg;

  // combinable conditions as separate flags; setup clears them all
  always_ff @(posedge REF_CLK) begin
    if (RST) begin
      cond_reg  <= '0;
      setup_reg <= 1'b0;
    end else if (wr && PADDR == A_COND_SET && PWDATA[C_SETUP] &&
                 cond_reg[C_INFO]) begin
      cond_reg  <= '0;
      setup_reg <= 1'b1;
    end else if (setup_reg) begin
      if (wr && PADDR == A_COND_CLR && PWDATA[C_SETUP]) begin
        setup_reg <= 1'b0;
      end
    end else begin
      for (int i = 0; i < N_COND; i++) begin
        if (wr && PADDR == A_COND_CLR && PWDATA[i]) begin
          cond_reg[i] <= 1'b0;
        end
      end
      // sets come last so an event never loses to a clear
      if (wr && PADDR == A_COND_SET) begin
        for (int i = 0; i < N_COND; i++) begin
          if (PWDATA[i] && i != C_INFO) begin
            cond_reg[i] <= 1'b1;
          end
        end
        if (PWDATA[C_MENU] && !FATAL_FAULT) begin
          cond_reg[C_INFO] <= 1'b1;
        end
      end
      if (FIRE_DET && FIRE_ZONE != ZONE_SVC && FIRE_ZONE <= ZONE_MAX) begin
        cond_reg[C_FIRE] <= 1'b1;
      end
      if (LOOP_FAULT || VOLT_FAULT || FATAL_FAULT || res_flt ||
          (state_reg inside {PMLR_SYSW, PMLR_POLLW} &&
           POLL_ACK && !poll_eq)) begin
        cond_reg[C_FAULT] <= 1'b1;
      end
    end
  end

  // software registers and key actions
  always_ff @(posedge REF_CLK) begin
    if (RST) begin
      auto_reg    <= CTRL_AUTO_RST;
      rec_idx_reg <= '0;
      sil_reg     <= 1'b0;
      stop_reg    <= 1'b0;
    end else begin
      if (wr && PADDR == A_CTRL) auto_reg <= PWDATA[CTRL_AUTO];
      if (wr && PADDR == A_REC_IDX) rec_idx_reg <= PWDATA[POS_W-1:0];
      if (!cond_reg[C_FIRE]) begin
        sil_reg <= 1'b0;
      end else if (wr && PADDR == A_KEY && ACCESS_L2) begin
        if (PWDATA[K_SIL]) sil_reg <= 1'b1;
        if (PWDATA[K_REEN]) sil_reg <= 1'b0;
      end
      if (!cond_reg[C_FIRE] && !cond_reg[C_FAULT]) begin
        stop_reg <= 1'b0;
      end else if (wr && PADDR == A_KEY && PWDATA[K_STOP]) begin
        stop_reg <= 1'b1;
      end
    end
  end

  // active input count saturates at both ends
  always_ff @(posedge REF_CLK) begin
    if (RST) begin
      act_reg <= '0;
    end else if (ACT_IN_SET && !ACT_IN_CLR && act_reg != ACT_MAX) begin
      act_reg <= act_reg + 1'b1;
    end else if (ACT_IN_CLR && !ACT_IN_SET && act_reg != '0) begin
      act_reg <= act_reg - 1'b1;
    end
  end

  pmlr_bl #(.TIMEOUT(BL_CYC)) u_bl (
    .clk      (REF_CLK),
    .rst      (RST),
    .hold     ((cond_reg[C_FIRE] || (cond_reg[C_FAULT] && !MAINS_FAULT))
               && !stop_reg),
    .batt_low (BATT_LOW),
    .key      (key_press),
    .on       (bl_on)
  );

  // panel outputs, all registered except DUTY, which is decoded from setup_reg and cond_reg
  always_ff @(posedge REF_CLK) begin
    if (RST) begin
      relay_reg  <= 1'b0;
      linked_reg <= 1'b0;
      inout_reg  <= 1'b0;
      sys_reg    <= 1'b1;
      rein_reg   <= 1'b0;
      rdy_reg    <= 1'b0;
    end else begin
      relay_reg  <= cond_reg[C_FIRE];
      linked_reg <= cond_reg[C_FIRE] && !sil_reg;
      inout_reg  <= cond_reg[C_FIRE] && IN_OUT_REQ;
      sys_reg    <= state_next inside {PMLR_SYS, PMLR_SYSW};
      rdy_reg    <= state_next == PMLR_RUN;
      rein_reg   <= (evt && !UNIT_GONE && auto_reg) ||
                    state_next == PMLR_WALK || pend_reg != '0;
    end
  end

  assign result_reg = {12'h000, rs_reg, ri_reg, ru_reg, rm_reg,
                       2'b00, rp_reg, ra_reg};

  always_comb begin
    case (PADDR)
      A_CTRL:    rd_mux = {31'h0, auto_reg};
      A_STATUS:  rd_mux = {20'h0, removed_reg != '0, sil_reg, bl_on,
                           rein_reg, sys_reg, DUTY, setup_reg, cond_reg};
      A_ACTIN:   rd_mux = {24'h0, act_reg};
      A_REC_IDX: rd_mux = {26'h0, rec_idx_reg};
      A_RESULT:  rd_mux = result_reg;
      default:   rd_mux = '0;
    endcase
  end

  // data is captured in setup so the access phase completes at once
  always_ff @(posedge REF_CLK) begin
    if (RST) begin
      prdata_reg  <= '0;
      pready_reg  <= 1'b0;
      pslverr_reg <= 1'b0;
    end else begin
      pready_reg  <= rd;
      pslverr_reg <= rd && !hit;
      if (rd && !PWRITE) prdata_reg <= rd_mux;
    end
  end

  assign PRDATA       = prdata_reg;
  assign PREADY       = pready_reg;
  assign PSLVERR      = pslverr_reg;
  assign UNIT_RDY     = rdy_reg;
  assign POLL_REQ     = preq_reg;
  assign POLL_ADDR    = poll_idx_reg;
  assign RES_VALID    = rv_reg;
  assign RES_POS      = rp_reg;
  assign RES_ADDR     = ra_reg;
  assign RES_MISMATCH = rm_reg;
  assign RES_UNINIT   = ru_reg;
  assign RES_IGNORED  = ri_reg;
  assign RES_SVC      = rs_reg;
  assign FIRE_RELAY   = relay_reg;
  assign LINKED_OUT   = linked_reg;
  assign INPUT_OUT    = inout_reg;
  assign BACKLIGHT    = bl_on;
  assign SYSOPS_MSG   = sys_reg;
  assign REINIT_MSG   = rein_reg;
  assign SETUP        = setup_reg;
  assign DUTY         = !setup_reg && cond_reg == '0;

  sequence s_auto_evt;
    evt && auto_reg && !UNIT_GONE && !UNIT_NEW && !UNIT_AMBIG;
  endsequence

  property p_match;
    @(posedge REF_CLK) disable iff (RST)
    s_auto_evt and full_eq |=> RES_VALID && !RES_SVC &&
      RES_ADDR == $past(rec_addr);
  endproperty
  a_match: assert property (p_match) else $error("match not restored");

  property p_mism;
    @(posedge REF_CLK) disable iff (RST)
    s_auto_evt and !full_eq |=> RES_MISMATCH && RES_SVC &&
      RES_ADDR == ADDR_W'($past(UNIT_POS)) ##1 cond_reg[C_FAULT];
  endproperty
  a_mism: assert property (p_mism) else $error("mismatch handling");

  property p_ambig;
    @(posedge REF_CLK) disable iff (RST)
    evt && auto_reg && UNIT_AMBIG && !UNIT_GONE && !UNIT_NEW |=>
      RES_UNINIT && RES_SVC && RES_ADDR == ADDR_W'($past(free_idx));
  endproperty
  a_ambig: assert property (p_ambig) else $error("ambiguous unit");

  property p_setup;
    @(posedge REF_CLK) disable iff (RST)
    SETUP |-> cond_reg == '0 && !DUTY;
  endproperty
  a_setup: assert property (p_setup) else $error("setup not exclusive");

  property p_menu_fatal;
    @(posedge REF_CLK) disable iff (RST)
    wr && PADDR == A_COND_SET && FATAL_FAULT && !cond_reg[C_INFO] |=>
      !cond_reg[C_INFO];
  endproperty
  a_menu_fatal: assert property (p_menu_fatal) else $error("menu in fatal");

  property p_relay;
    @(posedge REF_CLK) disable iff (RST)
    cond_reg[C_FIRE] |=> FIRE_RELAY;
  endproperty
  a_relay: assert property (p_relay) else $error("fire relay off");

  property p_inout;
    @(posedge REF_CLK) disable iff (RST)
    INPUT_OUT |-> $past(cond_reg[C_FIRE]) && $past(IN_OUT_REQ);
  endproperty
  a_inout: assert property (p_inout) else $error("input out no fire");

  property p_count;
    @(posedge REF_CLK) disable iff (RST)
    ACT_IN_SET && !ACT_IN_CLR && act_reg < ACT_MAX |=>
      act_reg == $past(act_reg) + 8'h01;
  endproperty
  a_count: assert property (p_count) else $error("active count");

  property p_batt;
    @(posedge REF_CLK) disable iff (RST)
    BATT_LOW [*2] |-> !BACKLIGHT;
  endproperty
  a_batt: assert property (p_batt) else $error("backlight on low batt");

endmodule : pmlr_top

// >>> hw/pmlr_pkg.sv
// pmlr_pkg: register map, field layout, zones, timing for the panel core
// assumes a 200 MHz REF_CLK and an apb master with 32-bit data
package pmlr_pkg;

  // loop unit table
  localparam int unsigned POS_W   = 6;
  localparam int unsigned N_UNITS = 64;
  localparam int unsigned DATA_W  = 24;
  localparam int unsigned ADDR_W  = 8;
  localparam int unsigned ID_LSB  = 8;
  localparam int unsigned REC_ADDR_LSB = 24;

  // apb byte addresses
  localparam logic [7:0] A_CTRL     = 8'h00;
  localparam logic [7:0] A_COND_SET = 8'h04;
  localparam logic [7:0] A_COND_CLR = 8'h08;
  localparam logic [7:0] A_STATUS   = 8'h0c;
  localparam logic [7:0] A_ACTIN    = 8'h10;
  localparam logic [7:0] A_REC_IDX  = 8'h14;
  localparam logic [7:0] A_REC_DATA = 8'h18;
  localparam logic [7:0] A_RESULT   = 8'h1c;
  localparam logic [7:0] A_KEY      = 8'h20;

  // condition bits in COND_SET, COND_CLR, STATUS
  localparam int unsigned N_COND  = 5;
  localparam int unsigned C_FIRE  = 0;
  localparam int unsigned C_FAULT = 1;
  localparam int unsigned C_DIS   = 2;
  localparam int unsigned C_TEST  = 3;
  localparam int unsigned C_INFO  = 4;
  localparam int unsigned C_SETUP = 5;
  localparam int unsigned C_MENU  = 6;
  localparam int unsigned S_DUTY  = 6;
  localparam int unsigned S_SYSOP = 7;
  localparam int unsigned S_REIN  = 8;
  localparam int unsigned S_BL    = 9;
  localparam int unsigned S_SIL   = 10;
  localparam int unsigned S_REM   = 11;

  // key register bits and ctrl
  localparam int unsigned K_PRESS = 0;
  localparam int unsigned K_STOP  = 1;
  localparam int unsigned K_SIL   = 2;
  localparam int unsigned K_REEN  = 3;
  localparam int unsigned CTRL_AUTO = 0;
  localparam logic CTRL_AUTO_RST = 1'b1;

  // result register fields
  localparam int unsigned R_POS_LSB = 8;
  localparam int unsigned R_MIS = 16;
  localparam int unsigned R_UNI = 17;
  localparam int unsigned R_IGN = 18;
  localparam int unsigned R_SVC = 19;

  // zones and addresses
  localparam logic [7:0] ZONE_SVC    = 8'h00;
  localparam logic [7:0] ZONE_MAX    = 8'h40;
  localparam logic [7:0] ZONE_NOFIRE = 8'hff;
  localparam logic [7:0] TEMP_ADDR   = 8'hfe;
  localparam logic [7:0] ACT_MAX     = 8'hff;

  // backlight timeout
  localparam longint unsigned CLK_HZ         = 200_000_000;
  localparam longint unsigned SEC_PER_MIN    = 60;
  localparam longint unsigned BL_TIMEOUT_MIN = 3;
  localparam longint unsigned BL_TIMEOUT_CYC =
    BL_TIMEOUT_MIN * SEC_PER_MIN * CLK_HZ;
  localparam int unsigned BL_CNT_W = 40;

  typedef enum logic [2:0] {
    PMLR_SYS, PMLR_SYSW, PMLR_RUN, PMLR_POLLW, PMLR_WALK
  } pmlr_state_e;

endpackage : pmlr_pkg

// >>> hw/pmlr_rec.sv
// pmlr_rec: nonvolatile image of loop unit records, one word per position
// assumes writes come from the register block, reads are combinational
`timescale 1ns/1ps
module pmlr_rec import pmlr_pkg::*; (
  // clock
  input  wire logic              clk,
  // write side
  input  wire logic              we,
  input  wire logic [POS_W-1:0]  widx,
  input  wire logic [31:0]       wdata,
  // read side
  input  wire logic [POS_W-1:0]  ridx,
  output logic      [31:0]       rdata
);
  // no reset: contents are loaded by software before use
  logic [31:0] mem [N_UNITS];

  always_ff @(posedge clk) begin
    if (we) begin
      mem[widx] <= wdata;
    end
  end

  assign rdata = mem[ridx];

endmodule : pmlr_rec

// >>> hw/pmlr_bl.sv
// pmlr_bl: display backlight hold and idle timeout
// assumes level inputs synchronous to clk and a one-cycle key pulse
`timescale 1ns/1ps
module pmlr_bl import pmlr_pkg::*; #(
  parameter longint unsigned TIMEOUT = BL_TIMEOUT_CYC
) (
  // clock and reset
  input  wire logic clk,
  input  wire logic rst,
  // panel state
  input  wire logic hold,
  input  wire logic batt_low,
  input  wire logic key,
  // backlight
  output logic      on
);
  logic [BL_CNT_W-1:0] cnt_reg;
  logic                on_reg;

  always_ff @(posedge clk) begin
    if (rst) begin
      cnt_reg <= '0;
    end else if (key) begin
      cnt_reg <= BL_CNT_W'(TIMEOUT);
    end else if (cnt_reg != '0) begin
      cnt_reg <= cnt_reg - 1'b1;
    end
  end

  // low battery wins over everything to save charge
  always_ff @(posedge clk) begin
    if (rst) begin
      on_reg <= 1'b0;
    end else begin
      on_reg <= !batt_low && (hold || key || cnt_reg != '0);
    end
  end

  assign on = on_reg;

endmodule : pmlr_bl

// >>> verification/pmlr_loop_model.sv
// pmlr_loop_model: addressable loop units answering the core's polls
// assumes one poll outstanding; replies only while en is high
`timescale 1ns/1ps
module pmlr_loop_model import pmlr_pkg::*; (
  // clock, hold-off
  input  wire logic              clk,
  input  wire logic              en,
  // poll
  input  wire logic              req,
  input  wire logic [POS_W-1:0]  addr,
  output logic                   ack,
  output logic      [DATA_W-1:0] data
);
  logic pend = 0;
  initial ack = 0;
  initial data = 0;
  // released line toggles so a stale word never looks valid
  always @(posedge clk) begin
    ack <= 0;
    data <= ~data;
    if (req)
      pend <= 1;
    else if (pend && en) begin
      pend <= 0;
      ack <= 1;
      data <= {10'h0, addr, 8'h5a};
    end
  end
endmodule : pmlr_loop_model

// >>> verification/pmlr_top_test.sv
// pmlr_top_test: modes, backlight and loop re-initialization
// assumes pmlr_loop_model answers polls once go is high
`timescale 1ns/1ps
module pmlr_top_test import pmlr_pkg::*;;
  logic REF_CLK = 0, RST = 1, PSEL = 0, PENABLE = 0, PWRITE = 0, go = 0;
  logic UNIT_EVT = 0, UNIT_GONE = 0, UNIT_NEW = 0, UNIT_AMBIG = 0;
  logic FIRE_DET = 0, LOOP_FAULT = 0, VOLT_FAULT = 0, FATAL_FAULT = 0;
  logic BATT_LOW = 0, MAINS_FAULT = 0, ACCESS_L2 = 0, ACT_IN_SET = 0;
  logic ACT_IN_CLR = 0, IN_OUT_REQ = 0, er;
  logic [7:0] PADDR = 0, FIRE_ZONE = 0, RES_ADDR;
  logic [31:0] PWDATA = 0, PRDATA, rd;
  logic [POS_W-1:0] UNIT_POS = 0, POLL_ADDR, RES_POS;
  logic [DATA_W-1:0] UNIT_DATA = 0, POLL_DATA;
  logic PREADY, PSLVERR, UNIT_RDY, POLL_REQ, POLL_ACK, RES_VALID, RES_SVC;
  logic RES_MISMATCH, RES_UNINIT, RES_IGNORED, FIRE_RELAY, LINKED_OUT;
  logic INPUT_OUT, BACKLIGHT, SYSOPS_MSG, REINIT_MSG, DUTY, SETUP;
  int fails = 0, n_compared = 0, cyc = 0;
  // short backlight count keeps the run brief
  pmlr_top #(.BL_CYC(20)) pmlr_top_i (.REF_CLK, .RST, .PSEL, .PENABLE,
    .PWRITE, .PADDR, .PWDATA, .PRDATA, .PREADY, .PSLVERR, .UNIT_EVT,
    .UNIT_GONE, .UNIT_NEW, .UNIT_AMBIG, .UNIT_POS, .UNIT_DATA, .UNIT_RDY,
    .POLL_REQ, .POLL_ADDR, .POLL_ACK, .POLL_DATA, .FIRE_DET, .FIRE_ZONE,
    .LOOP_FAULT, .VOLT_FAULT, .FATAL_FAULT, .BATT_LOW, .MAINS_FAULT,
    .ACCESS_L2, .ACT_IN_SET, .ACT_IN_CLR, .IN_OUT_REQ, .RES_VALID,
    .RES_POS, .RES_ADDR, .RES_MISMATCH, .RES_UNINIT, .RES_IGNORED,
    .RES_SVC, .FIRE_RELAY, .LINKED_OUT, .INPUT_OUT, .BACKLIGHT,
    .SYSOPS_MSG, .REINIT_MSG, .DUTY, .SETUP);
  pmlr_loop_model pmlr_loop_model_i (.clk(REF_CLK), .en(go),
    .req(POLL_REQ), .addr(POLL_ADDR), .ack(POLL_ACK), .data(POLL_DATA));
  always #2.5 REF_CLK = ~REF_CLK;
  always @(posedge REF_CLK) if (++cyc > 20000) begin
    fails++;
    wrap_up();
  end
  function automatic logic [23:0] ud(input logic [5:0] p);
    return {10'h0, p, 8'h5a};
  endfunction : ud
  task automatic chk(input string n, input logic [31:0] g, e);
    n_compared++;
    if (g !== e) begin
      fails++;
      $display("unexpected %s: expected %h seen %h", n, e, g);
    end
  endtask : chk
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge REF_CLK);
    PSEL <= 1;
    PWRITE <= w;
    PADDR <= a;
    PWDATA <= d;
    @(posedge REF_CLK);
    PENABLE <= 1;
    do @(posedge REF_CLK); while (PREADY !== 1);
    rd = PRDATA;
    er = PSLVERR;
    PSEL <= 0;
    PENABLE <= 0;
  endtask : apb
  task automatic uev(input logic [2:0] k, input logic [5:0] p,
                     input logic [23:0] d);
    @(posedge REF_CLK);
    {UNIT_GONE, UNIT_NEW, UNIT_AMBIG} <= k;
    UNIT_POS <= p;
    UNIT_DATA <= d;
    UNIT_EVT <= 1;
    do @(posedge REF_CLK); while (UNIT_RDY !== 1);
    UNIT_EVT <= 0;
  endtask : uev
  task automatic res(input logic [5:0] p, input logic [7:0] a,
                     input logic [2:0] f);
    int i = 0;
    do @(posedge REF_CLK); while (RES_VALID !== 1 && ++i < 80);
    chk("res", {RES_VALID, RES_POS, RES_ADDR, RES_MISMATCH, RES_UNINIT,
        RES_IGNORED}, {1'b1, p, a, f});
  endtask : res
  task automatic wrap_up();
    $display("compared %0d fails %0d", n_compared, fails);
    if (fails == 0 && n_compared > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask : wrap_up
  initial begin
    repeat (4) @(posedge REF_CLK);
    RST <= 0;
    chk("sysop", {SYSOPS_MSG, DUTY}, 2'b11);
    for (int p = 0; p < 64; p++) begin
      apb(1, A_REC_IDX, p);
      apb(1, A_REC_DATA, {8'(p), ud(6'(p))});
    end
    go <= 1;
    while (UNIT_RDY !== 1) @(posedge REF_CLK);
    apb(0, A_STATUS, 0);
    chk("st", {SYSOPS_MSG, rd[6:0]}, 8'h40);
    FATAL_FAULT <= 1;
    apb(1, A_COND_SET, 32'h40);
    FATAL_FAULT <= 0;
    apb(0, A_STATUS, 0);
    chk("st", rd[6:0], 7'h02);
    IN_OUT_REQ <= 1;
    ACCESS_L2 <= 1;
    apb(1, A_COND_SET, 32'h4d);
    apb(0, A_STATUS, 0);
    chk("st", {FIRE_RELAY, LINKED_OUT, rd[6:0]}, 9'h19f);
    apb(1, A_KEY, 32'h4);
    repeat (30) @(posedge REF_CLK);
    apb(0, A_STATUS, 0);
    chk("out", {rd[10], LINKED_OUT, INPUT_OUT, BACKLIGHT}, 4'hb);
    apb(1, A_KEY, 32'h2);
    apb(0, A_STATUS, 0);
    chk("stop", {rd[9], BACKLIGHT}, 2'b00);
    apb(1, A_COND_SET, 32'h20);
    apb(0, A_STATUS, 0);
    chk("st", {SETUP, FIRE_RELAY, rd[6:0]}, 9'h120);
    apb(1, A_COND_CLR, 32'h20);
    apb(0, A_STATUS, 0);
    chk("st", {DUTY, rd[6:0]}, 8'hc0);
    for (int z = 65; z > 63; z--) begin
      FIRE_ZONE <= 8'(z);
      FIRE_DET <= 1;
      @(posedge REF_CLK);
      FIRE_DET <= 0;
      apb(0, A_STATUS, 0);
      chk("fz", rd[0], 65 - z);
    end
    apb(1, A_COND_CLR, 32'h1);
    ACT_IN_SET <= 1;
    @(posedge REF_CLK);
    ACT_IN_SET <= 0;
    apb(1, A_KEY, 32'h1);
    apb(0, A_ACTIN, 0);
    chk("act", {BACKLIGHT, rd[7:0]}, 9'h101);
    repeat (25) @(posedge REF_CLK);
    chk("bl", BACKLIGHT, 0);
    BATT_LOW <= 1;
    apb(1, A_KEY, 32'h1);
    apb(0, A_STATUS, 0);
    chk("batt", {rd[9], BACKLIGHT}, 2'b00);
    BATT_LOW <= 0;
    uev(4, 5, 0);
    uev(0, 5, ud(5));
    res(5, 5, 0);
    chk("msg", REINIT_MSG, 1);
    uev(4, 7, 0);
    uev(0, 7, ~ud(7));
    res(7, 7, 4);
    chk("svc", RES_SVC, 1);
    for (int p = 20; p < 23; p++) uev(4, 6'(p), 0);
    uev(1, 21, ud(21));
    res(21, 20, 2);
    uev(1, 22, ~ud(22));
    uev(0, 20, ud(20));
    res(20, 20, 0);
    res(21, 21, 0);
    chk("svc", RES_SVC, 0);
    res(22, 22, 4);
    uev(2, 40, ud(40));
    res(40, TEMP_ADDR, 1);
    apb(1, A_CTRL, 0);
    uev(4, 9, 0);
    uev(0, 9, ud(9) ^ 24'h5);
    res(9, 9, 0);
    uev(2, 41, ud(41));
    res(41, 0, 1);
    apb(0, 8'h24, 0);
    chk("err", {er, rd[7:0]}, 9'h100);
    wrap_up();
  end
endmodule : pmlr_top_test
